// ---- design/clk_ctrl_pkg.sv ----
// Package for the run-mode clock control block: register offsets,
// field positions, reset values, encodings and timing counts.
// Assumes a 32-bit APB slave on pclk at 10 MHz.
package clk_ctrl_pkg;

  // Register byte offsets
  localparam logic [11:0] OFF_RUN_CFG      = 12'h060;
  localparam logic [11:0] OFF_RUN_CFG_EXT  = 12'h070;
  localparam logic [11:0] OFF_XLATE        = 12'h064;
  localparam logic [11:0] OFF_RAW_STATUS   = 12'h050;
  localparam logic [11:0] OFF_IRQ_MASK     = 12'h054;
  localparam logic [11:0] OFF_MASKED_STAT  = 12'h058;
  localparam logic [11:0] OFF_PERIPH_EN    = 12'h100;
  localparam logic [11:0] OFF_DEEP_CFG     = 12'h144;

  // Primary register fields
  localparam int RC_OSC_LSB     = 4;   // oscillator_source [5:4]
  localparam int RC_CRYSTAL_NUMBER_LSB    = 6;   // crystal_number [9:6]
  localparam int RC_BYPASS_BIT  = 11;
  localparam int RC_PLL_POWER_DOWN_BIT   = 13;
  localparam int RC_USEDIV_BIT  = 22;
  localparam int RC_DIV_LSB     = 23;  // system_divider [26:23]

  // Extended register fields
  localparam int RX_OSC_LSB     = 4;   // oscillator_source_ext [6:4]
  localparam int RX_BYPASS_BIT  = 11;
  localparam int RX_PLL_POWER_DOWN_BIT   = 13;
  localparam int RX_DIV_LSB     = 23;  // system_divider_ext [28:23]
  localparam int RX_SEL_BIT     = 31;  // ext_config_select

  // Deep-sleep register fields
  localparam int DS_DIV_LSB     = 23;
  localparam int DS_OSC_LSB     = 4;
  localparam int DS_OVR_BIT     = 0;

  // Reset values: PLL bypassed and powered down, divider /16
  localparam logic [31:0] RST_RUN_CFG     = 32'h078E_3AC0;
  localparam logic [31:0] RST_RUN_CFG_EXT = 32'h07C0_6810;
  localparam logic [31:0] RST_DEEP_CFG    = 32'h0780_0000;

  // Field widths
  localparam int DIV_W     = 4;
  localparam int DIV_EXT_W = DIV_W + 2;
  localparam int CRYSTAL_NUMBER_W    = 4;

  // Oscillator source encodings
  typedef enum logic [2:0] {
    OSC_MAIN     = 3'h0,
    OSC_INT      = 3'h1,
    OSC_INT_DIV4 = 3'h2,
    OSC_INT_30K  = 3'h3,
    OSC_RTC_32K  = 3'h7
  } osc_src_e;

  // Timing
  localparam int          VCO_MHZ        = 400;
  localparam int          PLL_PREDIV     = 2;
  localparam logic [3:0]  MIN_PLL_DIV    = 4'h3;
  localparam logic [15:0] RELOCK_LOAD    = 16'h1200;

  // Lock FSM
  typedef enum logic [1:0] {
    LK_OFF     = 2'b00,
    LK_WAIT    = 2'b01,
    LK_LOCKED  = 2'b10
  } lock_e;

endpackage

// ---- design/clock_control.sv ----
// Run-mode system clock configuration, divider select and PLL relock
// control, reached over APB. Assumes the oscillators, PLL analog and the
// clock mux cell sit outside; this block drives their selects.
module clock_control
  import clk_ctrl_pkg::*;
#(
  parameter int PERIPH_W = 32        // Number of peripheral enables
) (
  input  wire  logic                 pclk,
  input  wire  logic                 presetn,
  input  wire  logic                 psel,
  input  wire  logic                 penable,
  input  wire  logic                 pwrite,
  input  wire  logic [11:0]          paddr,
  input  wire  logic [31:0]          pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire  logic                 main_osc_clk,
  input  wire  logic                 deep_sleep,
  output logic [2:0]                 oscillator_source,
  output logic                       pll_power_down,
  output logic [7:0]                 crystal_pll_translation,
  output logic                       system_clock_use_pll,
  output logic [5:0]                 system_divisor,
  output logic                       use_system_divider,
  output logic                       pll_lock_irq,
  output logic [PERIPH_W-1:0]        periph_clk_en
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0]          run_cfg;      // Primary register
    logic [31:0]          run_cfg_ext;  // Extended register
    logic [31:0]          deep_cfg;     // Deep-sleep register
    logic [PERIPH_W-1:0]  periph_en;    // Peripheral gates
    logic                 irq_mask;     // Lock interrupt mask
    logic                 lock_raw;     // Sticky lock status
    logic [15:0]          relock_cnt;   // Relock down-counter
    lock_e                lock_st;      // Lock state
    logic [2:0]           osc_sync;     // Main osc sampling chain
    logic                 use_pll;      // Registered mux select
    logic [31:0]          rdata;        // Read data register
  } state_s;

  state_s cur;
  state_s nxt;

  // Effective fields after override resolution
  logic                 ovr;
  logic                 eff_bypass;
  logic                 eff_pll_power_down;
  logic [2:0]           eff_osc;
  logic [5:0]           eff_div;
  logic [CRYSTAL_NUMBER_W-1:0]    crystal_number;
  logic [7:0]           xlate;
  logic                 osc_edge;
  logic                 acc_wr;
  logic                 acc_rd;
  logic                 mapped;
  logic                 relock_trig;
  logic                 pll_on_next;

  ////////////////////////////////////////////////////////////////////////
  // Field selection

  // Override bit picks the extended fields
  always_comb begin
    ovr = cur.run_cfg_ext[RX_SEL_BIT];
    if (ovr) begin
      eff_bypass = cur.run_cfg_ext[RX_BYPASS_BIT];
      eff_pll_power_down  = cur.run_cfg_ext[RX_PLL_POWER_DOWN_BIT];
      eff_osc    = cur.run_cfg_ext[RX_OSC_LSB +: 3];
      eff_div    = cur.run_cfg_ext[RX_DIV_LSB +: DIV_EXT_W];
    end else begin
      eff_bypass = cur.run_cfg[RC_BYPASS_BIT];
      eff_pll_power_down  = cur.run_cfg[RC_PLL_POWER_DOWN_BIT];
      eff_osc    = {1'b0, cur.run_cfg[RC_OSC_LSB +: 2]};
      eff_div    = {2'b00, cur.run_cfg[RC_DIV_LSB +: DIV_W]};
    end
    // Deep sleep may override divider and source
    if (deep_sleep && cur.deep_cfg[DS_OVR_BIT]) begin
      eff_div = cur.deep_cfg[DS_DIV_LSB +: DIV_EXT_W];
      eff_osc = cur.deep_cfg[DS_OSC_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Crystal translation

  // Table of loop settings per crystal number; fixed, not programmable
  always_comb begin
    crystal_number = cur.run_cfg[RC_CRYSTAL_NUMBER_LSB +: CRYSTAL_NUMBER_W];
    unique case (crystal_number)
      4'h0:    xlate = 8'h70;
      4'h1:    xlate = 8'h6C;
      4'h2:    xlate = 8'h60;
      4'h3:    xlate = 8'h58;
      4'h4:    xlate = 8'h51;
      4'h5:    xlate = 8'h4B;
      4'h6:    xlate = 8'h49;
      4'h7:    xlate = 8'h44;
      4'h8:    xlate = 8'h3F;
      4'h9:    xlate = 8'h3C;
      4'hA:    xlate = 8'h3A;
      4'hB:    xlate = 8'h37;
      4'hC:    xlate = 8'h33;
      4'hD:    xlate = 8'h31;
      4'hE:    xlate = 8'h2F;
      default: xlate = 8'h2C;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Zero-wait APB slave; unmapped addresses raise pslverr
  always_comb begin
    acc_wr = psel && penable && pwrite;
    acc_rd = psel && !penable && !pwrite;
    unique case (paddr)
      OFF_RUN_CFG, OFF_RUN_CFG_EXT, OFF_XLATE, OFF_RAW_STATUS,
      OFF_IRQ_MASK, OFF_MASKED_STAT, OFF_PERIPH_EN,
      OFF_DEEP_CFG: mapped = 1'b1;
      default:      mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt = cur;
    // Main oscillator sampled; 2nd stage high with 3rd stage low marks a rise
    nxt.osc_sync = {cur.osc_sync[1:0], main_osc_clk};
    osc_edge = cur.osc_sync[1] && !cur.osc_sync[2];

    // Register writes
    relock_trig = 1'b0;
    if (acc_wr && mapped) begin
      unique case (paddr)
        OFF_RUN_CFG: begin
          nxt.run_cfg = pwdata;
          // Only a real change of crystal relocks
          if (pwdata[RC_CRYSTAL_NUMBER_LSB +: CRYSTAL_NUMBER_W] != crystal_number) begin
            relock_trig = 1'b1;
          end
        end
        OFF_RUN_CFG_EXT: nxt.run_cfg_ext = pwdata;
        OFF_IRQ_MASK:    nxt.irq_mask = pwdata[6];
        OFF_MASKED_STAT: begin
          // Write one clears the lock flag
          if (pwdata[6]) begin
            nxt.lock_raw = 1'b0;
          end
        end
        OFF_PERIPH_EN:   nxt.periph_en = pwdata[PERIPH_W-1:0];
        OFF_DEEP_CFG:    nxt.deep_cfg = pwdata;
        default:         nxt.rdata = cur.rdata;
      endcase
    end

    // Power-down effect of the next configuration
    pll_on_next = (nxt.run_cfg_ext[RX_SEL_BIT]) ?
                  !nxt.run_cfg_ext[RX_PLL_POWER_DOWN_BIT] :
                  !nxt.run_cfg[RC_PLL_POWER_DOWN_BIT];

    // Lock sequencing
    unique case (cur.lock_st)
      LK_OFF: begin
        if (pll_on_next) begin
          nxt.relock_cnt = RELOCK_LOAD;
          nxt.lock_st    = LK_WAIT;
        end
      end
      LK_WAIT: begin
        if (!pll_on_next) begin
          nxt.lock_st = LK_OFF;
        end else if (relock_trig) begin
          nxt.relock_cnt = RELOCK_LOAD;
        end else if (osc_edge) begin
          if (cur.relock_cnt == 16'h0001) begin
            nxt.lock_st  = LK_LOCKED;
            nxt.lock_raw = 1'b1;
          end
          nxt.relock_cnt = cur.relock_cnt - 16'h0001;
        end
      end
      LK_LOCKED: begin
        if (!pll_on_next) begin
          nxt.lock_st = LK_OFF;
        end else if (relock_trig) begin
          nxt.relock_cnt = RELOCK_LOAD;
          nxt.lock_st    = LK_WAIT;
        end
      end
      default: nxt.lock_st = LK_OFF;
    endcase

    // PLL feeds the clock only once locked; else raw oscillator
    nxt.use_pll = !eff_bypass && (nxt.lock_st == LK_LOCKED);

    // Read data captured in the setup cycle
    if (acc_rd) begin
      unique case (paddr)
        OFF_RUN_CFG:     nxt.rdata = cur.run_cfg;
        OFF_RUN_CFG_EXT: nxt.rdata = cur.run_cfg_ext;
        OFF_XLATE:       nxt.rdata = {24'h0, xlate};
        OFF_RAW_STATUS:  nxt.rdata = {25'h0, cur.lock_raw, 6'h0};
        OFF_IRQ_MASK:    nxt.rdata = {25'h0, cur.irq_mask, 6'h0};
        OFF_MASKED_STAT: nxt.rdata = {25'h0,
                                      cur.lock_raw & cur.irq_mask, 6'h0};
        OFF_PERIPH_EN:   nxt.rdata = 32'(cur.periph_en);
        OFF_DEEP_CFG:    nxt.rdata = cur.deep_cfg;
        default:         nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // PLL powered down and lock cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur.run_cfg     <= RST_RUN_CFG;
      cur.run_cfg_ext <= RST_RUN_CFG_EXT;
      cur.deep_cfg    <= RST_DEEP_CFG;
      cur.periph_en   <= '0;
      cur.irq_mask    <= 1'b0;
      cur.lock_raw    <= 1'b0;
      cur.relock_cnt  <= 16'h0000;
      cur.lock_st     <= LK_OFF;
      cur.osc_sync    <= 3'h0;
      cur.use_pll     <= 1'b0;
      cur.rdata       <= 32'h0000_0000;
    end else begin
      cur <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Mux select changes only on a registered edge; the external cell
  // completes the switch on its own clock boundaries
  assign system_clock_use_pll          = cur.use_pll;
  assign oscillator_source       = eff_osc;
  assign pll_power_down          = eff_pll_power_down;
  assign crystal_pll_translation = xlate;
  // Divisor reported as code; with PLL the 400 MHz is halved first
  assign system_divisor          = eff_div;
  // Divider skipped only when bypassing with divider off
  assign use_system_divider      = !eff_bypass ||
                                   cur.run_cfg[RC_USEDIV_BIT];
  assign pll_lock_irq            = cur.lock_raw & cur.irq_mask;
  assign periph_clk_en           = cur.periph_en;
  assign prdata                  = cur.rdata;
  assign pready                  = 1'b1;
  assign pslverr                 = psel && penable && !mapped;

endmodule

// ---- tb/clock_control_assertions.sv ----
// Port-level timing checks for the run-mode clock control block.
// Assumes a single pclk domain and presetn async active low.
module clock_control_assertions
  import clk_ctrl_pkg::*;
#(
  parameter int PERIPH_W = 32
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic                pslverr,
  input wire logic                deep_sleep,
  input wire logic [2:0]          oscillator_source,
  input wire logic                pll_power_down,
  input wire logic [7:0]          crystal_pll_translation,
  input wire logic                system_clock_use_pll,
  input wire logic [5:0]          system_divisor,
  input wire logic [PERIPH_W-1:0] periph_clk_en
);
  logic        wr_acc;   // Completed write
  logic [15:0] lock_cyc; // Pclk cycles since last relock cause

  assign wr_acc = psel && penable && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////
  // Oscillator is slower than pclk, so pclk count bounds lock time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cyc <= 16'h0000;
    end else if ($fell(pll_power_down) || $changed(crystal_pll_translation)) begin
      lock_cyc <= 16'h0000;
    end else if (lock_cyc != 16'hFFFF) begin
      lock_cyc <= lock_cyc + 16'h0001;
    end
  end

  sequence power_up_s; $fell(pll_power_down); endsequence
  sequence held_off_s; !system_clock_use_pll [*8]; endsequence

  ////////////////////////////////////////////////////////////////////
  relock_hold_a: assert property (power_up_s |-> held_off_s)
    else $error("pll used right after power up");
  relock_count_a: assert property ($rose(system_clock_use_pll) |->
    lock_cyc >= RELOCK_LOAD) else $error("pll used before relock");
  pll_powered_a: assert property ($rose(system_clock_use_pll) |->
    !pll_power_down) else $error("pll used while down");
  down_blocks_a: assert property (pll_power_down [*3] |->
    !system_clock_use_pll) else $error("pll used while down");
  crystal_number_restart_a: assert property ($changed(crystal_pll_translation) &&
    !pll_power_down |-> ##[1:4] !system_clock_use_pll) else $error("no relock");
  xlate_write_a: assert property ($changed(crystal_pll_translation) |->
    $past(wr_acc)) else $error("translation moved");
  div_stable_a: assert property (!$past(wr_acc) && $stable(deep_sleep)
    |-> $stable(system_divisor)) else $error("divisor moved");
  osc_stable_a: assert property (!$past(wr_acc) && $stable(deep_sleep)
    |-> $stable(oscillator_source)) else $error("source moved");
  periph_write_a: assert property ($changed(periph_clk_en) |->
    $past(wr_acc)) else $error("enables moved");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
endmodule

bind clock_control clock_control_assertions #(.PERIPH_W(PERIPH_W)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .pslverr, .deep_sleep,
  .oscillator_source, .pll_power_down, .crystal_pll_translation,
  .system_clock_use_pll, .system_divisor, .periph_clk_en);

// ---- tb/test_clock_control.sv ----
// Self-checking bench for the clock control block over APB.
// Assumes zero-wait APB and a free main oscillator at pclk/4.
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t mismatch %h vs %h", $time, (a), (e)); end end
module test_clock_control;
  import clk_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, lk;
  logic        main_osc_clk, deep_sleep, err, pll_power_down;
  logic        system_clock_use_pll, use_system_divider, pll_lock_irq;
  logic [2:0]  oscillator_source;
  logic [7:0]  crystal_pll_translation;
  logic [5:0]  system_divisor;
  logic [31:0] periph_clk_en;
  logic [1:0]  ph;           // Oscillator phase
  int          failures, n_compared, i, n, s;

  clock_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .main_osc_clk, .deep_sleep,
    .oscillator_source, .pll_power_down, .crystal_pll_translation,
    .system_clock_use_pll, .system_divisor, .use_system_divider, .pll_lock_irq,
    .periph_clk_en);

  ////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Fast main oscillator keeps the relock wait short
  always @(posedge pclk) begin
    ph <= ph + 2'd1;
    if (ph[0]) main_osc_clk <= ~main_osc_clk;
  end

  // Replace one field of a register image
  function automatic logic [31:0] put(logic [31:0] r, int l, int w, logic [31:0] f);
    logic [31:0] m;
    m = (32'h1 << w) - 32'h1;
    return (r & ~(m << l)) | ((f & m) << l);
  endfunction
  // Pclk cycles for one relock at four pclk per oscillator edge
  function automatic int lk_cyc();
    return 4 * int'(RELOCK_LOAD);
  endfunction

  // One APB transfer; data taken at the pready edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic rd_chk(logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Bounded wait for the pll select to reach a level
  task automatic wait_pll(logic e, output int c);
    c = 0;
    while (system_clock_use_pll !== e && c < 40000) begin
      @(negedge pclk);
      c++;
    end
  endtask
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, deep_sleep, main_osc_clk} = 6'h00;
    {paddr, pwdata, ph, failures, n_compared} = '0;
    s = $urandom(74759);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(pll_power_down, 1'b1)
    `CHK(system_clock_use_pll, 1'b0)
    `CHK(system_divisor, 6'h0F)
    `CHK(use_system_divider, 1'b0)
    rd_chk(OFF_RUN_CFG, RST_RUN_CFG);
    rd_chk(OFF_RUN_CFG_EXT, RST_RUN_CFG_EXT);
    rd_chk(OFF_XLATE, {24'h0, crystal_pll_translation});
    $display("reset test done");
    // Divider codes, both widths, ends included
    for (i = 0; i < 10; i++) begin
      v = (i == 0) ? 32'h0 : (i == 1) ? 32'h3F : $urandom;
      apb(1'b1, OFF_RUN_CFG, put(RST_RUN_CFG, RC_DIV_LSB, DIV_W, v));
      `CHK(system_divisor, {2'b00, v[3:0]})
      lk = put(RST_RUN_CFG_EXT, RX_DIV_LSB, DIV_EXT_W, v);
      apb(1'b1, OFF_RUN_CFG_EXT, lk | 32'h8000_0000);
      `CHK(system_divisor, v[5:0])
      apb(1'b1, OFF_RUN_CFG_EXT, RST_RUN_CFG_EXT);
    end
    // Every source code, then the extended 32 kHz code
    for (i = 0; i < 4; i++) begin
      v = put(RST_RUN_CFG, RC_OSC_LSB, 2, i) | (32'h1 << RC_USEDIV_BIT);
      apb(1'b1, OFF_RUN_CFG, v);
      `CHK(oscillator_source, i[2:0])
      `CHK(use_system_divider, 1'b1)
    end
    lk = put(RST_RUN_CFG_EXT, RX_OSC_LSB, 3, 7);
    apb(1'b1, OFF_RUN_CFG_EXT, lk | 32'h8000_0000);
    `CHK(oscillator_source, 3'h7)
    apb(1'b1, OFF_RUN_CFG_EXT, RST_RUN_CFG_EXT);
    `CHK(oscillator_source, 3'h3)
    $display("divider test done");
    v = $urandom;
    apb(1'b1, OFF_PERIPH_EN, v);
    `CHK(periph_clk_en, v)
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
    rd_chk(12'h0FC, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, OFF_DEEP_CFG, put(32'h1, DS_DIV_LSB, 6, 5));
    @(posedge pclk) deep_sleep <= 1'b1;
    @(negedge pclk);
    `CHK(system_divisor, 6'h05)
    @(posedge pclk) deep_sleep <= 1'b0;
    $display("misc test done");
    // Power up and select pll in one write; main osc already runs
    apb(1'b1, OFF_IRQ_MASK, 32'h40);
    lk = RST_RUN_CFG & ~32'h0000_2800;
    apb(1'b1, OFF_RUN_CFG, lk);
    wait_pll(1'b1, n);
    `CHK(n >= lk_cyc() - 8 && n <= lk_cyc() + 24, 1'b1)
    apb(1'b0, OFF_RAW_STATUS, 32'h0);
    `CHK(rd[6], 1'b1)
    `CHK(pll_lock_irq, 1'b1)
    apb(1'b1, OFF_MASKED_STAT, 32'h40);
    `CHK(pll_lock_irq, 1'b0)
    apb(1'b1, OFF_RUN_CFG, lk);
    repeat (50) @(posedge pclk);
    `CHK(system_clock_use_pll, 1'b1)
    // Crystal code kept inside the supported range
    apb(1'b1, OFF_RUN_CFG, put(lk, RC_CRYSTAL_NUMBER_LSB, CRYSTAL_NUMBER_W, 32'hC));
    rd_chk(OFF_XLATE, {24'h0, crystal_pll_translation});
    wait_pll(1'b0, n);
    `CHK(n < 4, 1'b1)
    wait_pll(1'b1, n);
    `CHK(n >= lk_cyc() - 16, 1'b1)
    `CHK(pll_lock_irq, 1'b1)
    apb(1'b1, OFF_IRQ_MASK, 32'h0);
    `CHK(pll_lock_irq, 1'b0)
    apb(1'b1, OFF_RUN_CFG, RST_RUN_CFG);
    @(negedge pclk);
    `CHK(system_clock_use_pll, 1'b0)
    $display("lock test done");
    stop_test();
  end

  // Cuts a hang short at well over two relock times
  initial begin
    repeat (90000) @(posedge pclk);
    failures++;
    stop_test();
  end
endmodule
